//--- rtl/pdt_pkg.sv
// package: register map, field layouts and delay lookup tables for the dma channel
package pdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte offsets)
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] TIMING_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] COUNT_OFS  = 4'hC;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] TIMING_RST = 32'h0000_0000;

  // channel_control_reg
  typedef struct packed {
    logic [13:0] rsvd;
    logic        enable;
    logic [1:0]  prefetch_count_code;
    logic [2:0]  hold_cycle_count;
    logic [5:0]  wait_cycle_count;
    logic [1:0]  setup_cycle_count;
    logic        buffer_on;
    logic [1:0]  periph_width_code;
    logic        transfer_direction;
  } pdt_ctrl_t;

  // sdram_timing_reg
  typedef struct packed {
    logic [28:0] rsvd;
    logic [1:0]  clock_ratio_code;
    logic        cas_latency_setting;
  } pdt_timing_t;

  localparam logic       DIR_M2P     = 1'b0;
  localparam logic [1:0] CODE_MAX    = 2'b10;
  localparam logic [2:0] P2M_EXP     = 3'd5;
  localparam logic [2:0] M2P_EXP     = 3'd3;
  localparam logic [6:0] GAP_LAST    = 7'd1;

  ////////////////////////////////////////////////////////////////////////////
  // delay rows: one nibble per clock ratio, lowest nibble is 2:1
  localparam logic [15:0] T2_M2P [4] = '{16'h457A, 16'h4569, 16'h567B, 16'h457A};
  localparam logic [15:0] T2_P2M [3] = '{16'h3457, 16'h3347, 16'h3346};
  localparam logic [15:0] T3_M2P     = 16'h2223;
  localparam logic [15:0] T3_P2M [2] = '{16'h2234, 16'h1223};
  localparam logic [15:0] T4_M2P [12] = '{
    16'h567B, 16'h457A, 16'h568B, 16'h457A,
    16'h568C, 16'h567B, 16'h568C, 16'h568B,
    16'h679E, 16'h579D, 16'h67AE, 16'h679D};
  localparam logic [15:0] T4_P2M [2] = '{16'h4569, 16'h3458};

  function automatic logic [3:0] pdt_nib(input logic [15:0] row, input logic [1:0] r);
    pdt_nib = row[{r, 2'b00} +: 4];
  endfunction

endpackage

//--- rtl/pdt_dma_channel.sv
// peripheral-mode dma channel: acknowledge pacing, sdram delay and buffer batching
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// - unbuffered ack spacing is setup+1+wait+hold plus sdram term.
// - unbuffered sdram term looked up by direction, cas, hold, ratio.
// - buffered inbound gathers up to 32 bytes, then one sdram write.
// - buffered outbound loads prefetch-selected doublewords into buffer.
// - one shared 32-byte buffer, flushed when channel is preempted.
// - buffer flushed when the active request deasserts.
// - buffered spacing is setup+1+wait+hold plus buffer term.
// - buffer term looked up by direction, hold and ratio.
// - full or empty buffer triggers sdram access with memory term.
// - outbound memory term looked up by prefetch, cas, hold, ratio.
// - inbound memory term looked up by hold and ratio.
// - inbound items per buffer equal 32 bytes over peripheral width.
// - inbound buffer cycle is (2^(5-width)-1) buffered gaps plus one.
// - outbound items per load are 2^(3+prefetch-width).
// - idle setup, ack for 1+wait, idle hold, in bus clocks.
// - width codes byte/half/word; prefetch codes one/two/four.
// - unbuffered mode does one sdram operation per item.
// - ack is the sole peripheral strobe, no address or select.
module pdt_dma_channel (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        periph_bus_clock,
  input  wire logic        periph_xfer_req,
  output logic             periph_xfer_ack,
  input  wire logic        channel_preempt,
  output logic             sdram_access,
  output logic             buffer_flush
);
  import pdt_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GAP,
    ST_ACK
  } pdt_state_t;

  //////////////////////////////////////////////////////////////////////////
  // registers
  pdt_ctrl_t   ctrl_q;
  pdt_timing_t timing_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        pclk_s1_q;
  logic        pclk_s2_q;
  logic        pclk_s3_q;
  logic        req_s1_q;
  logic        req_s2_q;
  pdt_state_t  state_q;
  pdt_state_t  state_d;
  logic [6:0]  cnt_q;
  logic [6:0]  cnt_d;
  logic        ack_q;
  logic        ack_d;
  logic [5:0]  items_q;
  logic [5:0]  items_d;
  logic        mem_q;
  logic        mem_d;
  logic        flush_q;
  logic        flush_d;
  logic [15:0] xfer_q;
  logic [15:0] xfer_d;

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers; request stage two feeds logic, bus clock stages two and three feed the edge detect
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pclk_s1_q <= 1'b0;
      pclk_s2_q <= 1'b0;
      pclk_s3_q <= 1'b0;
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
    end else begin
      pclk_s1_q <= periph_bus_clock;
      pclk_s2_q <= pclk_s1_q;
      pclk_s3_q <= pclk_s2_q;
      req_s1_q  <= periph_xfer_req;
      req_s2_q  <= req_s1_q;
    end
  end

  // all pacing counts whole peripheral bus clocks, one step per rising edge
  wire pedge = pclk_s2_q & ~pclk_s3_q;

  //////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the access completes
  wire        wr_take  = avs_write & ~wait_q;
  wire        rd_load  = avs_read & wait_q;
  wire        sel_ctrl = avs_address == CTRL_OFS;
  wire        sel_tim  = avs_address == TIMING_OFS;
  wire        sel_stat = avs_address == STATUS_OFS;
  wire        sel_cnt  = avs_address == COUNT_OFS;
  logic [31:0] be_mask;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  wire [31:0] ctrl_wd = ({ctrl_q} & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] tim_wd  = ({timing_q} & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] stat_w  = {22'h00_0000, items_q, req_s2_q, ack_q, state_q};
  wire [31:0] rd_mux  = sel_ctrl ? {ctrl_q} :
                        sel_tim  ? {timing_q} :
                        sel_stat ? stat_w :
                        sel_cnt  ? {16'h0000, xfer_q} : 32'h0000_0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
    end
  end

  // reserved bits are kept at zero so they read back as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q   <= pdt_ctrl_t'(CTRL_RST);
      timing_q <= pdt_timing_t'(TIMING_RST);
      rdata_q  <= 32'h0000_0000;
    end else begin
      if (wr_take && sel_ctrl) begin
        ctrl_q      <= pdt_ctrl_t'(ctrl_wd);
        ctrl_q.rsvd <= 14'h0000;
      end
      if (wr_take && sel_tim) begin
        timing_q      <= pdt_timing_t'(tim_wd);
        timing_q.rsvd <= 29'h0000_0000;
      end
      if (rd_load) begin
        rdata_q <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration decode
  wire       m2p   = ctrl_q.transfer_direction == DIR_M2P;
  wire       buf_on = ctrl_q.buffer_on;
  wire [2:0] hold  = ctrl_q.hold_cycle_count;
  wire       hnz   = |hold;
  wire       hgt1  = |hold[2:1];
  wire [1:0] ratio = timing_q.clock_ratio_code;
  wire       cas3  = timing_q.cas_latency_setting;
  // reserved code 0b11 is treated as the largest legal code
  wire [1:0] pw    = (ctrl_q.periph_width_code > CODE_MAX) ? CODE_MAX
                                                          : ctrl_q.periph_width_code;
  wire [1:0] pf    = (ctrl_q.prefetch_count_code > CODE_MAX) ? CODE_MAX
                                                            : ctrl_q.prefetch_count_code;
  wire [1:0] p2m_hidx = hgt1 ? 2'd2 : {1'b0, hnz};

  wire [3:0] t2 = m2p ? pdt_nib(T2_M2P[{cas3, hnz}], ratio)
                      : pdt_nib(T2_P2M[p2m_hidx], ratio);
  wire [3:0] t3 = m2p ? pdt_nib(T3_M2P, ratio)
                      : pdt_nib(T3_P2M[hnz], ratio);
  wire [3:0] t4_m = pdt_nib(T4_M2P[{pf, cas3, hnz}], ratio);
  wire [3:0] t4_p = pdt_nib(T4_P2M[hnz], ratio);
  wire [3:0] t4   = m2p ? t4_m : t4_p;

  // inbound items = 32 bytes / width
  wire [2:0] exp_p2m = P2M_EXP - {1'b0, pw};
  wire [2:0] exp_m2p = M2P_EXP + {1'b0, pf} - {1'b0, pw};
  wire [2:0] ld_exp  = m2p ? exp_m2p : exp_p2m;
  wire [5:0] ld_items = 6'h01 << ld_exp;
  // last of a load ends the buffered run
  wire       last_item = items_q == (ld_items - 6'h01);
  // full or empty buffer takes the memory term
  wire       mem_next  = ~buf_on | last_item;

  // every unbuffered item gets its own sdram term
  wire [3:0] term_next  = ~buf_on ? t2 : (last_item ? t4 : t3);
  // outbound buffered data must be loaded before the first strobe
  wire [3:0] term_first = ~buf_on ? t2 : (m2p ? t4 : t3);
  wire       mem_first  = ~buf_on | m2p;

  // gap = hold + term + setup (first gap has no hold), ack lasts 1+wait
  // same form with the buffer term
  wire [6:0] gap_next  = {4'h0, hold} + {3'h0, term_next}
                       + {5'h00, ctrl_q.setup_cycle_count};
  wire [6:0] gap_first = {3'h0, term_first} + {5'h00, ctrl_q.setup_cycle_count};
  wire [6:0] ack_len   = {1'b0, ctrl_q.wait_cycle_count} + 7'd1;

  wire stop = ~req_s2_q | channel_preempt | ~ctrl_q.enable;

  //////////////////////////////////////////////////////////////////////////
  // pacing state machine
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ack_d   = ack_q;
    items_d = items_q;
    mem_d   = 1'b0;
    flush_d = 1'b0;
    xfer_d  = xfer_q;
    case (state_q)
      ST_IDLE: begin
        if (pedge && !stop) begin
          state_d = ST_GAP;
          cnt_d   = gap_first;
          items_d = 6'h00;
          mem_d   = mem_first;
        end
      end
      ST_GAP: begin
        if (stop) begin
          state_d = ST_IDLE;
          items_d = 6'h00;
          flush_d = buf_on;
        end else if (pedge) begin
          if (cnt_q == GAP_LAST) begin
            state_d = ST_ACK;
            ack_d   = 1'b1;
            cnt_d   = ack_len;
          end else begin
            cnt_d = cnt_q - 7'd1;
          end
        end
      end
      ST_ACK: begin
        // a strobe in progress is never cut short
        if (pedge) begin
          if (cnt_q == GAP_LAST) begin
            ack_d  = 1'b0;
            xfer_d = xfer_q + 16'h0001;
            if (stop) begin
              state_d = ST_IDLE;
              items_d = 6'h00;
              flush_d = buf_on;
            end else begin
              state_d = ST_GAP;
              cnt_d   = gap_next;
              items_d = mem_next ? 6'h00 : items_q + 6'h01;
              mem_d   = mem_next;
            end
          end else begin
            cnt_d = cnt_q - 7'd1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        ack_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 7'h00;
      ack_q   <= 1'b0;
      items_q <= 6'h00;
      mem_q   <= 1'b0;
      flush_q <= 1'b0;
      xfer_q  <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ack_q   <= ack_d;
      items_q <= items_d;
      mem_q   <= mem_d;
      flush_q <= flush_d;
      xfer_q  <= xfer_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign periph_xfer_ack = ack_q;
  assign sdram_access    = mem_q;
  assign buffer_flush    = flush_q;

endmodule // pdt_dma_channel

`default_nettype wire

//--- testbench/pdt_dma_channel_assertions.sv
// port checks for the dma channel
`timescale 1ns/1ps
`default_nettype none
module pdt_dma_channel_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        periph_bus_clock,
  input wire logic        periph_xfer_req,
  input wire logic        periph_xfer_ack,
  input wire logic        channel_preempt,
  input wire logic        sdram_access,
  input wire logic        buffer_flush
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_wait_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  // one bus clock is eight system clocks, so no strobe or gap is shorter
  property p_ack_high;
    $rose(periph_xfer_ack) |-> periph_xfer_ack [*7];
  endproperty
  property p_ack_low;
    $fell(periph_xfer_ack) |-> !periph_xfer_ack [*7];
  endproperty
  property p_sdram_gap;
    sdram_access |-> !periph_xfer_ack ##1 !sdram_access;
  endproperty
  property p_flush_pulse;
    buffer_flush |=> !buffer_flush;
  endproperty
  property p_flush_quiet;
    buffer_flush |-> !sdram_access && !periph_xfer_ack;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer after request");
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ack_high: assert property (p_ack_high) else $error("strobe too short");
  a_ack_low: assert property (p_ack_low) else $error("strobe gap too short");
  a_sdram_gap: assert property (p_sdram_gap) else $error("bad sdram pulse");
  a_flush_pulse: assert property (p_flush_pulse) else $error("long flush");
  a_flush_quiet: assert property (p_flush_quiet) else $error("flush beside strobe");
  c_ack: cover property ($rose(periph_xfer_ack));
  c_sdram: cover property (sdram_access);
  c_flush: cover property (buffer_flush);
endmodule // pdt_dma_channel_assertions

bind pdt_dma_channel pdt_dma_channel_assertions chk (
  .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .periph_bus_clock(periph_bus_clock), .periph_xfer_req(periph_xfer_req),
  .periph_xfer_ack(periph_xfer_ack), .channel_preempt(channel_preempt),
  .sdram_access(sdram_access), .buffer_flush(buffer_flush));
`default_nettype wire

//--- testbench/pdt_periph_model.sv
// peripheral model: free bus clock and a held request
`timescale 1ns/1ps
`default_nettype none
module pdt_periph_model (
  input  wire logic req_en,
  output logic      periph_bus_clock,
  output logic      periph_xfer_req
);
  // phase offset keeps bus clock edges away from system clock edges
  initial begin
    periph_bus_clock = 1'b0;
    #37;
    forever #200 periph_bus_clock = ~periph_bus_clock;
  end
  // no bus use between strobes
  // request starts low so the synchroniser never sees an unknown level
  initial begin
    periph_xfer_req = 1'b0;
    forever @(posedge periph_bus_clock) periph_xfer_req <= req_en;
  end
endmodule // pdt_periph_model
`default_nettype wire

//--- testbench/pdt_dma_channel_tb.sv
// self-checking bench for the dma channel
`timescale 1ns/1ps
`default_nettype none
module pdt_dma_channel_tb;
  import pdt_pkg::*;
  logic        clock, rst, avs_read, avs_write, avs_waitrequest, periph_bus_clock;
  logic        periph_xfer_req, periph_xfer_ack, channel_preempt, sdram_access;
  logic        buffer_flush, req_en;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, wv;
  logic [15:0] lf;
  int          failures, comparisons, pcnt, scnt;
  pdt_dma_channel uut (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .periph_bus_clock(periph_bus_clock), .periph_xfer_req(periph_xfer_req),
    .periph_xfer_ack(periph_xfer_ack), .channel_preempt(channel_preempt),
    .sdram_access(sdram_access), .buffer_flush(buffer_flush));
  pdt_periph_model peer (.req_en(req_en), .periph_bus_clock(periph_bus_clock),
    .periph_xfer_req(periph_xfer_req));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge periph_bus_clock) pcnt++;
  always @(posedge clock) if (sdram_access === 1'b1) scnt++;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string w);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, w, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, exp, input string w);
    chk(32'(got), 32'(exp), w);
  endtask
  task automatic wait_v(ref logic s, input logic v);
    int i;
    for (i = 0; i < 4000 && s !== v; i++) @(posedge clock);
    if (s !== v) begin
      failures++;
      $display("unexpected at %0t: wait timed out", $time);
      give_verdict();
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      failures++;
      $display("unexpected at %0t: bus timed out", $time);
      give_verdict();
    end
  endtask
  // seventeen strobe gaps are measured in bus clocks, then the flush path when buffered
  task automatic scen(input logic d, input logic [1:0] pw, input logic bon,
      input logic [1:0] s, input logic [5:0] w, input logic [2:0] h,
      input logic [1:0] pf, input logic [2:0] tim, input int bt, ct);
    int p0, s0, k, n, es;
    n = d ? 1 << (5 - pw) : 1 << (3 + pf - pw);
    es = 0;
    bus(1'h1, TIMING_OFS, {29'h0, tim});
    bus(1'h1, CTRL_OFS, {14'h0, 1'h1, pf, h, w, s, bon, pw, d});
    req_en <= 1'h1;
    wait_v(periph_xfer_ack, 1'h1);
    s0 = scnt;
    for (k = 1; k < 18; k++) begin
      p0 = pcnt;
      wait_v(periph_xfer_ack, 1'h0);
      wait_v(periph_xfer_ack, 1'h1);
      es += (!bon || k % n == 0);
      chk_cnt(pcnt - p0, s + 1 + w + h + ((bon && k % n) ? bt : ct), "gap");
    end
    chk_cnt(scnt - s0, es, "sdram ops");
    if (bon) begin
      if (d) req_en <= 1'h0;
      else channel_preempt <= 1'h1;
      wait_v(buffer_flush, 1'h1);
      chk(periph_xfer_ack, 1'h0, "ack at flush");
      bus(1'h0, STATUS_OFS, 32'h0);
      chk(rd, {28'h0, !d, 3'h0}, "status after flush");
    end
    bus(1'h1, CTRL_OFS, 32'h0);
    req_en <= 1'h0;
    channel_preempt <= 1'h0;
    repeat (200) @(posedge clock);
  endtask
  initial begin
    {rst, req_en} = 2'h2;
    {avs_read, avs_write, channel_preempt} = 3'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    lf = 16'h5F80;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(rd, CTRL_RST, "ctrl reset");
    bus(1'h0, TIMING_OFS, 32'h0);
    chk(rd, TIMING_RST, "timing reset");
    lf = lfsr(lf);
    wv = {lf, lfsr(lf)} & 32'hFFFD_FFFF;
    bus(1'h1, CTRL_OFS, wv);
    bus(1'h1, 4'h2, 32'hFFFF_FFFF);
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(rd, wv & 32'h0003_FFFF, "ctrl");
    // only the enabled lane may change
    avs_byteenable <= 4'h1;
    bus(1'h1, CTRL_OFS, 32'hFFFF_FFFF);
    avs_byteenable <= 4'hF;
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(rd, (wv & 32'h0003_FF00) | 32'h0000_00FF, "byte lane write");
    bus(1'h0, 4'h2, 32'h0);
    chk(rd, 32'h0, "unmapped");
    scen(1'h1, 2'h2, 1'h0, lf[1:0], {4'h0, lf[3:2]}, 3'h1, 2'h0, 3'h0, 7, 7);
    scen(1'h0, 2'h0, 1'h0, 2'h2, 6'h1, 3'h0, 2'h0, 3'h3, 7, 7);
    scen(1'h1, 2'h2, 1'h1, 2'h0, 6'h0, 3'h1, 2'h0, 3'h0, 3, 8);
    scen(1'h0, 2'h2, 1'h1, 2'h0, 6'h0, 3'h0, 2'h2, 3'h0, 3, 14);
    scen(1'h1, 2'h1, 1'h1, 2'h1, 6'h2, 3'h2, 2'h0, 3'h6, 1, 3);
    // eighteen finished strobes per scenario, five scenarios
    bus(1'h0, COUNT_OFS, 32'h0);
    chk(rd, 32'h0000_005A, "strobe count");
    // reset in mid-strobe must drop the strobe and clear the count and control registers
    bus(1'h1, CTRL_OFS, 32'h0002_0001);
    req_en <= 1'h1;
    wait_v(periph_xfer_ack, 1'h1);
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    chk(periph_xfer_ack, 1'h0, "ack in reset");
    rst <= 1'h0;
    req_en <= 1'h0;
    bus(1'h0, COUNT_OFS, 32'h0);
    chk(rd, 32'h0000_0000, "count after reset");
    bus(1'h0, CTRL_OFS, 32'h0);
    chk(rd, CTRL_RST, "ctrl after reset");
    give_verdict();
  end
endmodule // pdt_dma_channel_tb
`default_nettype wire
